// file: devcfg_params.svh
// constants for the device configuration block
`ifndef DEVCFG_PARAMS_SVH
`define DEVCFG_PARAMS_SVH
`define CFG_BASE_ADDR 32'h01b3f000
`define CFG_WINDOW_BYTES 32'h00001000
`define OFS_PERIPH_ENABLE 12'h000
`define OFS_DEVICE_STATUS 12'h004
`define OFS_SCAN_ID 12'h008
`define OFS_CONFIG_LOCK 12'h00c
`define UNLOCK_KEY 32'h10c0010c
`define PEN_RESET 7'h06
`define PEN_WRITE_MASK 7'h6f
`define BIT_AUDIO_SEL 0
`define BIT_SERIAL_A 1
`define BIT_SERIAL_B 2
`define BIT_I2C0 3
`define BIT_VIDEO_A 5
`define BIT_VIDEO_B 6
`define BOOT_NONE 2'h0
`define BOOT_HOST 2'h1
`define BOOT_ROM8 2'h3
`define MCLK_PIN 2'h0
`define MCLK_DIV4 2'h1
`define MCLK_DIV6 2'h2
`endif

// file: devcfg_pkg.sv
// types shared by the device configuration block
`default_nettype none
package devcfg_pkg;
    typedef struct packed {
        logic ethernet_select_strap;
        logic host_width_strap;
        logic byte_order_strap;
        logic [3:0] memory_address_straps;
        logic general_pin_zero;
    } strap_t;
    typedef struct packed {
        logic byte_order_mode;
        logic [1:0] boot_mode;
        logic [1:0] memory_clock_source;
        logic host_port_width;
        logic host_lower_en;
        logic host_upper_en;
        logic ethernet_en;
        logic strap_invalid;
    } pin_config_t;
    typedef enum logic [1:0] {
        ST_IN_RESET = 2'b00,
        ST_CAPTURED = 2'b01
    } latch_state_t;
endpackage
`default_nettype wire

// file: strap_latch.sv
// samples the straps on the first clock edge after reset and freezes them afterwards
`timescale 1ns/1ps
`default_nettype none
module strap_latch (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // board straps
    input wire devcfg_pkg::strap_t straps,
    // held values
    output var devcfg_pkg::strap_t held
);
    devcfg_pkg::latch_state_t state_q;
    // async reset only loads constants; pins sampled on clocked edges
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= devcfg_pkg::ST_IN_RESET;
        end else begin
            state_q <= devcfg_pkg::ST_CAPTURED;
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            held <= '0;
        end else begin
            case (state_q)
                devcfg_pkg::ST_IN_RESET: held <= straps; // RL1 RL19
                devcfg_pkg::ST_CAPTURED: held <= held; // RL19
                default: held <= held;
            endcase
        end
    end
    strap_frozen_a: assert property (@(posedge clock) // RL19
        disable iff (!arst_n)
        state_q == devcfg_pkg::ST_CAPTURED |=> $stable(held))
        else $error("straps changed after capture");
endmodule // strap_latch
`default_nettype wire

// file: devcfg_regs.sv
// device configuration: reset straps and peripheral enables
//
// Function
// RL1: latch memory, byte order, width straps at reset
// RL2: ethernet strap with width selects pin use
// RL3: byte order 0 big, 1 little endian
// RL4: boot: none, host port, reserved, ROM
// RL5: memory clock: pin, CPU/4, CPU/6, reserved
// RL6: narrow host port floats upper sixteen pins
// RL7: ethernet strap enables ethernet, drops wide host
// RL8: board keeps general pin zero low
// RL9: host and ethernet share muxed pins
// RL10: timers and gpio always on
// RL11: registers in 4K window at fixed base
// RL12: status and scan id registers provided
// RL13: software enables video, serial, audio, i2c
// RL14: second serial enable resets to one
// RL15: software must clear second serial enable
// RL16: enable bit zero powers peripheral down
// RL17: audio select takes upper video pins
// RL18: enables accepted only after unlock key
// RL19: straps held until next reset
`timescale 1ns/1ps
`default_nettype none
`include "devcfg_params.svh"
module devcfg_regs #(
    parameter logic [31:0] SCAN_ID_VALUE = 32'h0000_0001 // arbitrary value
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // configuration bus
    input wire logic cfg_req,
    input wire logic cfg_wr,
    input wire logic [31:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    // board straps
    input wire devcfg_pkg::strap_t straps,
    // strap-derived configuration
    output devcfg_pkg::pin_config_t pin_cfg,
    // peripheral enables
    output logic video_port_a_enable,
    output logic video_port_b_enable,
    output logic serial_port_a_enable,
    output logic serial_port_b_enable,
    output logic i2c_ctrl0_enable,
    output logic audio_port_select,
    output logic video_a_upper_en,
    output logic always_on_enable
);
    localparam logic [31:0] BASE_ADDR = `CFG_BASE_ADDR;
    devcfg_pkg::strap_t held;
    logic [6:0] pen_q;
    logic locked_q;
    logic hit;
    logic [11:0] ofs;
    logic [31:0] rdata_d;
    logic [6:0] pen_wr;
    devcfg_pkg::pin_config_t cfg_d;

    strap_latch u_straps (
        .clock(clock),
        .arst_n(arst_n),
        .straps(straps),
        .held(held)
    );

    // decode within the 4K window
    assign hit = cfg_req &&
        (cfg_addr[31:12] == BASE_ADDR[31:12]); // RL11
    assign ofs = cfg_addr[11:0];

    // strap decode
    always_comb begin
        cfg_d.byte_order_mode = held.byte_order_strap; // RL3
        cfg_d.boot_mode = held.memory_address_straps[3:2]; // RL4
        cfg_d.memory_clock_source = held.memory_address_straps[1:0]; // RL5
        cfg_d.host_port_width = held.host_width_strap; // RL1
        // pin sharing per width and ethernet straps
        cfg_d.ethernet_en = held.ethernet_select_strap; // RL2 RL7
        cfg_d.host_lower_en = !(held.host_width_strap &&
            held.ethernet_select_strap); // RL7 RL9
        cfg_d.host_upper_en = held.host_width_strap &&
            !held.ethernet_select_strap; // RL6 RL9
        cfg_d.strap_invalid = held.general_pin_zero; // RL8
    end

    // pin config registered so outputs come from flops
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin_cfg <= '0;
        end else begin
            pin_cfg <= cfg_d; // RL2
        end
    end

    // lock: key unlocks, any other value written to the lock register relocks
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            locked_q <= 1'b1;
        end else if (hit && cfg_wr && ofs == `OFS_CONFIG_LOCK) begin
            locked_q <= (cfg_wdata != `UNLOCK_KEY); // RL18
        end
    end

    // while locked bits may only be cleared, never newly enabled
    always_comb begin
        pen_wr = (pen_q & ~`PEN_WRITE_MASK) |
            (cfg_wdata[6:0] & `PEN_WRITE_MASK);
        if (locked_q) begin
            pen_wr = pen_wr & pen_q; // RL18
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pen_q <= `PEN_RESET; // RL14
        end else if (hit && cfg_wr && ofs == `OFS_PERIPH_ENABLE) begin
            pen_q <= pen_wr; // RL13
        end
    end

    // enables; a zero keeps the peripheral powered down
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            video_port_a_enable <= 1'b0;
            video_port_b_enable <= 1'b0;
            serial_port_a_enable <= 1'b0;
            serial_port_b_enable <= 1'b0;
            i2c_ctrl0_enable <= 1'b0;
            audio_port_select <= 1'b0;
            video_a_upper_en <= 1'b0;
            always_on_enable <= 1'b0;
        end else begin
            video_port_a_enable <= pen_q[`BIT_VIDEO_A]; // RL16
            video_port_b_enable <= pen_q[`BIT_VIDEO_B]; // RL16
            serial_port_a_enable <= pen_q[`BIT_SERIAL_A]; // RL16
            serial_port_b_enable <= pen_q[`BIT_SERIAL_B]; // RL15
            i2c_ctrl0_enable <= pen_q[`BIT_I2C0]; // RL16
            audio_port_select <= pen_q[`BIT_AUDIO_SEL]; // RL17
            video_a_upper_en <= !pen_q[`BIT_AUDIO_SEL]; // RL17
            always_on_enable <= 1'b1; // RL10
        end
    end

    // read mux
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (ofs)
            `OFS_PERIPH_ENABLE: rdata_d = {25'h0, pen_q};
            `OFS_DEVICE_STATUS: rdata_d = {24'h0, held}; // RL12
            `OFS_SCAN_ID: rdata_d = SCAN_ID_VALUE; // RL12
            `OFS_CONFIG_LOCK: rdata_d = {31'h0, locked_q}; // RL18
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // one-cycle answer; unmapped offsets read zero
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg_ack <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_ack <= hit;
            cfg_rdata <= (hit && !cfg_wr) ? rdata_d : 32'h0000_0000;
        end
    end

    locked_no_set_a: assert property (@(posedge clock) // RL18
        disable iff (!arst_n)
        locked_q && hit && cfg_wr && ofs == `OFS_PERIPH_ENABLE
        |=> (pen_q & ~$past(pen_q)) == 7'h00)
        else $error("enable set while locked");
    unlock_key_a: assert property (@(posedge clock) // RL18
        disable iff (!arst_n)
        hit && cfg_wr && ofs == `OFS_CONFIG_LOCK &&
        cfg_wdata == `UNLOCK_KEY |=> !locked_q)
        else $error("key did not unlock");
    wide_blocks_eth_a: assert property (@(posedge clock) // RL9
        disable iff (!arst_n)
        pin_cfg.host_upper_en |-> !pin_cfg.ethernet_en)
        else $error("upper host pins and ethernet both on");
    audio_excl_a: assert property (@(posedge clock) // RL17
        disable iff (!arst_n)
        audio_port_select |-> !video_a_upper_en)
        else $error("audio and upper video pins both on");
    enable_follow_a: assert property (@(posedge clock) // RL16
        disable iff (!arst_n)
        1'b1 |=> video_port_b_enable == $past(pen_q[`BIT_VIDEO_B]))
        else $error("video b enable lags register");
    boot_decode_a: assert property (@(posedge clock) // RL4
        disable iff (!arst_n)
        1'b1 |=> pin_cfg.boot_mode == $past(held.memory_address_straps[3:2]))
        else $error("boot mode mismatch");
    clk_decode_a: assert property (@(posedge clock) // RL5
        disable iff (!arst_n)
        1'b1 |=> pin_cfg.memory_clock_source ==
        $past(held.memory_address_straps[1:0]))
        else $error("memory clock source mismatch");
    read_ack_a: assert property (@(posedge clock) // RL11
        disable iff (!arst_n)
        hit |=> cfg_ack)
        else $error("access not answered");
endmodule // devcfg_regs
`default_nettype wire

// file: strap_board.sv
// board strap resistor model for the device configuration block
`timescale 1ns/1ps
`default_nettype none
module strap_board (
    // strap choice of the board
    input wire devcfg_pkg::strap_t setting,
    // pins seen by the device
    output var devcfg_pkg::strap_t straps
);
    // pin zero held low, never fighting the internal pulldown
    always_comb begin
        straps = setting;
        straps.general_pin_zero = 1'b0;
    end
endmodule // strap_board
`default_nettype wire

// file: reset_strap_periph_config_tb.sv
// testbench for the device configuration register block
`timescale 1ns/1ps
`default_nettype none
`include "devcfg_params.svh"
module reset_strap_periph_config_tb;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic cfg_req = 1'b0;
    logic cfg_wr = 1'b0;
    logic [31:0] cfg_addr = 32'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic [31:0] cfg_rdata;
    logic cfg_ack;
    devcfg_pkg::strap_t setting = 8'h20;
    devcfg_pkg::strap_t straps;
    devcfg_pkg::pin_config_t pin_cfg;
    logic va, vb, sa, sb, i2c, aud, vup, aon;
    logic [7:0] en;
    logic [31:0] pc;
    logic [31:0] rd;
    logic ak;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    // every width/ethernet pair; boot codes 00 01 11, clock codes 00 01 10
    devcfg_pkg::strap_t tbl [4] = '{8'h20, 8'h8a, 8'h7c, 8'hda};

    devcfg_regs #(.SCAN_ID_VALUE(32'h0000_5a5a)) i_devcfg_regs (
        .clock(clock), .arst_n(arst_n), .cfg_req(cfg_req),
        .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .straps(straps),
        .pin_cfg(pin_cfg), .video_port_a_enable(va),
        .video_port_b_enable(vb), .serial_port_a_enable(sa),
        .serial_port_b_enable(sb), .i2c_ctrl0_enable(i2c),
        .audio_port_select(aud), .video_a_upper_en(vup),
        .always_on_enable(aon));
    strap_board i_strap_board (.setting(setting), .straps(straps));
    assign en = {va, vb, sa, sb, i2c, aud, vup, aon};
    assign pc = {22'h0, pin_cfg};

    always #5 clock = ~clock;

    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            err_count = err_count + 1;
            conclude();
        end
    end

    function automatic logic [31:0] at(input logic [11:0] ofs);
        at = `CFG_BASE_ADDR | {20'h0, ofs};
    endfunction

    function automatic logic [31:0] exp_cfg(input devcfg_pkg::strap_t s);
        exp_cfg = {22'h0, s.byte_order_strap, s.memory_address_straps,
            s.host_width_strap,
            ~(s.host_width_strap & s.ethernet_select_strap),
            s.host_width_strap & ~s.ethernet_select_strap,
            s.ethernet_select_strap, s.general_pin_zero};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        check_count = check_count + 1;
        if (got !== exp) begin
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
            err_count = err_count + 1;
        end
    endtask

    // one request, held across the taking edge; ack seen one cycle on
    task automatic access(input logic wr, input logic [31:0] a,
                          input logic [31:0] d);
        @(posedge clock);
        #1;
        cfg_req = 1'b1;
        cfg_wr = wr;
        cfg_addr = a;
        cfg_wdata = d;
        @(posedge clock);
        #1;
        cfg_req = 1'b0;
        rd = cfg_rdata;
        ak = cfg_ack;
    endtask

    task automatic rd_chk(input logic [11:0] ofs, input logic [31:0] exp,
                          input string msg);
        access(1'b0, at(ofs), 32'h0);
        chk({31'h0, ak}, 32'h1, msg);
        chk(rd, exp, msg);
    endtask

    task automatic do_reset(input devcfg_pkg::strap_t s);
        arst_n = 1'b0;
        setting = s;
        repeat (8) @(posedge clock);
        #1;
        arst_n = 1'b1;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 4; i++) begin
            do_reset(tbl[i]);
            chk(exp_cfg(tbl[i]), pc, "cfg");
            rd_chk(`OFS_DEVICE_STATUS, {24'h0, tbl[i]}, "status");
            setting = ~tbl[i];
            repeat (3) @(posedge clock);
            #1;
            chk(exp_cfg(tbl[i]), pc, "strap hold");
        end
        chk({24'h0, en}, 32'h33, "reset outs");
        rd_chk(`OFS_PERIPH_ENABLE, 32'h6, "enable reset");
        rd_chk(`OFS_CONFIG_LOCK, 32'h1, "locked");
        access(1'b1, at(`OFS_PERIPH_ENABLE), 32'h61);
        rd_chk(`OFS_PERIPH_ENABLE, 32'h0, "locked write");
        access(1'b1, at(`OFS_CONFIG_LOCK), `UNLOCK_KEY);
        rd_chk(`OFS_CONFIG_LOCK, 32'h0, "unlocked");
        access(1'b1, at(`OFS_PERIPH_ENABLE), 32'h61);
        rd_chk(`OFS_PERIPH_ENABLE, 32'h61, "enable write");
        chk({24'h0, en}, 32'hc5, "video on");
        access(1'b1, at(`OFS_PERIPH_ENABLE), 32'hffffffff);
        rd_chk(`OFS_PERIPH_ENABLE, {25'h0, `PEN_WRITE_MASK}, "resv");
        access(1'b1, at(`OFS_PERIPH_ENABLE), 32'h08);
        rd_chk(`OFS_SCAN_ID, 32'h0000_5a5a, "scan id");
        chk({24'h0, en}, 32'h0b, "i2c only");
        access(1'b1, at(`OFS_CONFIG_LOCK), 32'h0);
        rd_chk(`OFS_CONFIG_LOCK, 32'h1, "relocked");
        access(1'b1, at(`OFS_PERIPH_ENABLE), 32'h48);
        rd_chk(`OFS_PERIPH_ENABLE, 32'h08, "no set when locked");
        access(1'b1, at(`OFS_PERIPH_ENABLE), 32'h0);
        rd_chk(`OFS_PERIPH_ENABLE, 32'h0, "clear when locked");
        rd_chk(12'h010, 32'h0, "unmapped");
        access(1'b0, `CFG_BASE_ADDR + `CFG_WINDOW_BYTES, 32'h0);
        chk({31'h0, ak}, 32'h0, "outside window");
        conclude();
    end
endmodule // reset_strap_periph_config_tb
`default_nettype wire
